// File: core/dsc_cfg.svh
`ifndef DSC_CFG_SVH
`define DSC_CFG_SVH

// ----------------------------------------------------------------------
// Register byte addresses.
// ----------------------------------------------------------------------
`define DSC_ADDR_CTRL        12'h000
`define DSC_ADDR_WLDLY       12'h004
`define DSC_ADDR_STAT        12'h008
`define DSC_ADDR_CODE        12'h00C

// ----------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------
`define DSC_CTRL_EDGE_LSB    0
`define DSC_CTRL_DIFF        2
`define DSC_CTRL_GEAR2       3
`define DSC_CTRL_BANK_LSB    4
`define DSC_STAT_POL         0
`define DSC_STAT_STATE_LSB   1
`define DSC_STAT_SERVED      3
`define DSC_WLDLY_INV        7

// ----------------------------------------------------------------------
// Reset values and structure counts.
// ----------------------------------------------------------------------
`define DSC_WLDLY_RST        8'h00
`define DSC_GROUP_PINS       12
`define DSC_DATA_BITS        10
`define DSC_CODE_BITS        7
`define DSC_WLDLY_BITS       8
`define DSC_BURST_RISES      4'h4

`endif

// File: core/dsc_pkg.sv
package dsc_pkg;

  // ----------------------------------------------------------------------
  // Edge of the device on which the group sits.
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    DSC_EDGE_LEFT,
    DSC_EDGE_RIGHT,
    DSC_EDGE_TOP,
    DSC_EDGE_BOTTOM
  } dsc_edge_t;

  // ----------------------------------------------------------------------
  // Read control states.
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    DSC_RD_IDLE,
    DSC_RD_PRE,
    DSC_RD_FIRST,
    DSC_RD_BURST
  } dsc_rd_state_t;

endpackage

// File: core/dsc_sync3.sv
`timescale 1ns/10ps

module dsc_sync3 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] d,
  output      logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } dsc_sync_t;

  dsc_sync_t r;
  dsc_sync_t next_r;

  // A bit changes only once the second and third stages agree.
  always_comb begin
    next_r    = r;
    next_r.s1 = d;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    next_r.q  = (~(r.s2 ^ r.s3) & r.s3) | ((r.s2 ^ r.s3) & r.q);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign q = r.q;

endmodule

// File: core/dsc_strobe_ctrl.sv
`timescale 1ns/10ps
`include "dsc_cfg.svh"
// ----------------------------------------------------------------------
// Overview of operation
// RL1 - One cell in twelve holds strobe control for eleven data pins.
// RL2 - Differential strobe uses true and complement pins of the group.
// RL3 - Bottom edge offers single-rate registering only, no DDR.
// RL4 - Top edge has input DDR but no output gearing.
// RL5 - Groups on left, right and top carry ten data bits.
// RL6 - Left loop serves banks 0, 7, 6; right serves 1, 2, 3.
// RL7 - Loop tracks the strobe with the system clock into a 7-bit code.
// RL8 - Read strobe is delayed a quarter period and clocks the data pads.
// RL9 - A polarity select picks the sync register clock edge.
// RL10 - Polarity is chosen afresh at the start of every read.
// RL11 - Memory drives the idle strobe low to start the preamble.
// RL12 - First strobe rise after the preamble sets the polarity.
// RL13 - Double gearbox mode pulses a latch moving pairs to second pair.
// RL14 - Write control makes two gearing clocks for data and strobe.
// RL15 - Write strobe gets extra leveling delay of up to 127 steps.
// RL16 - Top bit of leveling delay inverts the write strobe clock.
// RL17 - Outside controller chooses the leveling delay; block applies it.
// RL18 - Top edge still drives address and command outputs.
// RL19 - Rise and fall captures form two streams synced to system clock.
// RL20 - An undriven strobe reads high and feeds preamble detection.
// RL21 - Polarity stays fixed for the whole read burst.
// ----------------------------------------------------------------------

module dsc_strobe_ctrl #(
  parameter int GROUP_PINS = `DSC_GROUP_PINS,
  parameter int DQ_W       = `DSC_DATA_BITS,
  parameter int CMD_W      = 8,
  parameter bit DLL_LEFT   = 1'b1
) (
  input  wire logic             CLK,
  input  wire logic             RESET,
  input  wire logic             PSEL,
  input  wire logic             PENABLE,
  input  wire logic             PWRITE,
  input  wire logic [11:0]      PADDR,
  input  wire logic [31:0]      PWDATA,
  output      logic [31:0]      PRDATA,
  output      logic             PREADY,
  output      logic             PSLVERR,
  input  wire logic             STROBE_IN,
  input  wire logic             STROBE_COMP_IN,
  input  wire logic [DQ_W-1:0]  DQ_IN,
  input  wire logic             READ_START,
  input  wire logic             WRITE_EN,
  input  wire logic [DQ_W-1:0]  WR_DATA_RISE,
  input  wire logic [DQ_W-1:0]  WR_DATA_FALL,
  input  wire logic [CMD_W-1:0] CMD_IN,
  output      logic [CMD_W-1:0] CMD_OUT,
  output      logic             STROBE_OUT,
  output      logic             STROBE_COMP_OUT,
  output      logic             STROBE_OE,
  output      logic [DQ_W-1:0]  DQ_OUT,
  output      logic             DQ_OE,
  output      logic [6:0]       DLL_DELAY_CODE,
  output      logic             DELAYED_READ_STROBE_CLOCK,
  output      logic             SYNC_CLOCK_POLARITY,
  output      logic             GEARBOX_TRANSFER_LATCH,
  output      logic [DQ_W-1:0]  RD_DATA_RISE,
  output      logic [DQ_W-1:0]  RD_DATA_FALL,
  output      logic [DQ_W-1:0]  RD_DATA_RISE_B,
  output      logic [DQ_W-1:0]  RD_DATA_FALL_B,
  output      logic             RD_VALID,
  output      logic             WRITE_GEAR_CLOCK_A,
  output      logic             WRITE_GEAR_CLOCK_B,
  output      logic             WRITE_STROBE_CLOCK
);
  import dsc_pkg::*;

  localparam int CW = `DSC_CODE_BITS;
  localparam int RH = 1 << CW;
  localparam int WH = 1 << `DSC_WLDLY_BITS;
  localparam int PW = DQ_W + 2;

  // Data pins of the group: all cells but the strobe cell.
  localparam int GROUP_DATA = GROUP_PINS - 1; // RL1

  typedef struct packed {
    dsc_edge_t       edge_sel;
    logic            diff;
    logic            gear2;
    logic [2:0]      bank;
    logic [7:0]      wldly;
    logic [31:0]     prdata;
    logic            pready;
    logic            pslverr;
    logic            s_prev;
    logic [CW-1:0]   half_cnt;
    logic [CW-1:0]   code;
    logic [RH-1:0]   hist_r;
    logic            drs;
    logic            drs_prev;
    dsc_rd_state_t   rd_state;
    logic            phase;
    logic            polarity;
    logic [3:0]      rises;
    logic [DQ_W-1:0] cap_rise;
    logic [DQ_W-1:0] cap_fall;
    logic [1:0]      pend;
    logic [DQ_W-1:0] rd_rise;
    logic [DQ_W-1:0] rd_fall;
    logic [DQ_W-1:0] rd_rise_b;
    logic [DQ_W-1:0] rd_fall_b;
    logic            rd_valid;
    logic            latch_tog;
    logic            latch;
    logic [1:0]      gear_cnt;
    logic            gear_a;
    logic            gear_b;
    logic [WH-1:0]   hist_w;
    logic            wsc;
    logic            strobe_out;
    logic            strobe_comp_out;
    logic            strobe_oe;
    logic [DQ_W-1:0] dq_out;
    logic            dq_oe;
    logic [CMD_W-1:0] cmd_out;
  } dsc_state_t;

  dsc_state_t      r;
  dsc_state_t      next_r;
  logic [PW-1:0]   pin_q;
  logic            strobe;
  logic [DQ_W-1:0] dq;
  logic            ddr_ok;
  logic            gear_ok;
  logic            served;
  logic            apb_setup;
  logic            apb_wr;
  logic            s_rise;
  logic            drs_rise;
  logic            drs_fall;
  logic            fall_evt;
  logic            xfer;
  logic [7:0]      wtap;

  // ----------------------------------------------------------------------
  // Pin synchroniser for strobe pair and data.
  // ----------------------------------------------------------------------
  dsc_sync3 #(
    .W (PW)
  ) u_pin_sync (
    .clk   (CLK),
    .reset (RESET),
    .d     ({STROBE_COMP_IN, STROBE_IN, DQ_IN}),
    .q     (pin_q)
  );

  // ----------------------------------------------------------------------
  // Next state.
  // ----------------------------------------------------------------------
  always_comb begin
    next_r    = r;
    // An undriven pair reads high, so the idle strobe is seen as one.
    strobe    = r.diff ? (pin_q[DQ_W] | ~pin_q[DQ_W+1]) : pin_q[DQ_W]; // RL2 RL20
    dq        = pin_q[DQ_W-1:0];
    ddr_ok    = r.edge_sel != DSC_EDGE_BOTTOM; // RL3
    gear_ok   = r.edge_sel == DSC_EDGE_LEFT ||
                r.edge_sel == DSC_EDGE_RIGHT; // RL4
    served    = DLL_LEFT ? (r.bank == 3'h0 || r.bank == 3'h7 ||
                            r.bank == 3'h6)
                         : (r.bank == 3'h1 || r.bank == 3'h2 ||
                            r.bank == 3'h3); // RL6
    apb_setup = PSEL & ~PENABLE;
    apb_wr    = PSEL & PENABLE & r.pready & PWRITE;
    s_rise    = strobe & ~r.s_prev;
    drs_rise  = r.drs & ~r.drs_prev;
    drs_fall  = ~r.drs & r.drs_prev;
    fall_evt  = 1'b0;
    xfer      = r.polarity ? r.pend[1] : r.pend[0]; // RL9
    wtap      = {1'b0, r.code} + {1'b0, r.wldly[6:0]}; // RL15

    // APB slave: one wait-free access phase after each setup.
    next_r.pready  = apb_setup;
    next_r.pslverr = 1'b0;
    next_r.prdata  = '0;
    if (apb_setup) begin
      case (PADDR)
        `DSC_ADDR_CTRL: begin
          next_r.prdata[`DSC_CTRL_EDGE_LSB +: 2] = r.edge_sel;
          next_r.prdata[`DSC_CTRL_DIFF]          = r.diff;
          next_r.prdata[`DSC_CTRL_GEAR2]         = r.gear2;
          next_r.prdata[`DSC_CTRL_BANK_LSB +: 3] = r.bank;
        end
        `DSC_ADDR_WLDLY: begin
          next_r.prdata[7:0] = r.wldly;
        end
        `DSC_ADDR_STAT: begin
          next_r.prdata[`DSC_STAT_POL]            = r.polarity;
          next_r.prdata[`DSC_STAT_STATE_LSB +: 2] = r.rd_state;
          next_r.prdata[`DSC_STAT_SERVED]         = served;
        end
        `DSC_ADDR_CODE: begin
          next_r.prdata[CW-1:0] = r.code;
        end
        default: begin
          next_r.pslverr = 1'b1;
        end
      endcase
    end
    if (apb_wr) begin
      case (PADDR)
        `DSC_ADDR_CTRL: begin
          next_r.edge_sel = dsc_edge_t'(PWDATA[`DSC_CTRL_EDGE_LSB +: 2]);
          next_r.diff     = PWDATA[`DSC_CTRL_DIFF];
          next_r.gear2    = PWDATA[`DSC_CTRL_GEAR2];
          next_r.bank     = PWDATA[`DSC_CTRL_BANK_LSB +: 3];
        end
        `DSC_ADDR_WLDLY: begin
          next_r.wldly = PWDATA[7:0]; // RL17
        end
        default: begin
        end
      endcase
    end

    // Delay loop: steer the code to half of each measured half period.
    next_r.s_prev = strobe;
    if (strobe != r.s_prev) begin
      next_r.half_cnt = 7'h1;
      if (served && r.code < (r.half_cnt >> 1)) begin
        next_r.code = r.code + 7'h1; // RL7
      end else if (served && r.code > (r.half_cnt >> 1)) begin
        next_r.code = r.code - 7'h1; // RL7
      end
    end else if (r.half_cnt != '1) begin
      next_r.half_cnt = r.half_cnt + 7'h1;
    end

    // Quarter period delayed read strobe.
    next_r.hist_r   = {r.hist_r[RH-2:0], strobe};
    next_r.drs      = r.hist_r[r.code]; // RL8
    next_r.drs_prev = r.drs;
    next_r.phase    = ~r.phase;

    // Read control.
    case (r.rd_state)
      DSC_RD_IDLE: begin
        if (READ_START && ddr_ok) begin
          next_r.rd_state = DSC_RD_PRE;
        end
      end
      DSC_RD_PRE: begin
        if (!strobe) begin
          next_r.rd_state = DSC_RD_FIRST; // RL11
        end
      end
      DSC_RD_FIRST: begin
        if (s_rise) begin
          next_r.polarity  = r.phase; // RL10 RL12
          next_r.rises     = '0;
          next_r.latch_tog = 1'b0;
          next_r.rd_state  = DSC_RD_BURST;
        end
      end
      DSC_RD_BURST: begin
        if (drs_rise) begin
          next_r.rises    = r.rises + 4'h1;
          next_r.cap_rise = dq; // RL19
        end
        if (drs_fall && r.rises != '0) begin
          next_r.cap_fall = dq; // RL19
          fall_evt        = 1'b1;
          if (r.rises == `DSC_BURST_RISES) begin
            next_r.rd_state = DSC_RD_IDLE;
          end
        end
      end
      default: begin
        next_r.rd_state = DSC_RD_IDLE;
      end
    endcase

    // Transfer of the two streams into the system clock domain.
    next_r.pend     = {r.pend[0], fall_evt};
    next_r.latch    = 1'b0;
    next_r.rd_valid = 1'b0;
    if (!ddr_ok) begin
      next_r.rd_rise  = dq; // RL3
      next_r.rd_valid = 1'b1;
    end else if (xfer) begin
      next_r.rd_rise = r.cap_rise; // RL19
      next_r.rd_fall = r.cap_fall;
      if (r.gear2 && gear_ok) begin
        next_r.latch_tog = ~r.latch_tog;
        if (r.latch_tog) begin
          next_r.rd_rise_b = r.rd_rise; // RL13
          next_r.rd_fall_b = r.rd_fall;
          next_r.latch     = 1'b1;
          next_r.rd_valid  = 1'b1;
        end
      end else begin
        next_r.rd_valid = 1'b1;
      end
    end

    // Write gearing clocks in quadrature and the leveled strobe.
    next_r.gear_cnt = r.gear_cnt + 2'h1;
    next_r.gear_a   = gear_ok & r.gear_cnt[1]; // RL14
    next_r.gear_b   = gear_ok & (r.gear_cnt[1] ^ r.gear_cnt[0]); // RL14
    next_r.hist_w   = {r.hist_w[WH-2:0], r.gear_a};
    next_r.wsc      = r.hist_w[wtap] ^ r.wldly[`DSC_WLDLY_INV]; // RL15 RL16
    next_r.strobe_oe       = WRITE_EN & gear_ok;
    next_r.strobe_out      = WRITE_EN & gear_ok & r.wsc;
    next_r.strobe_comp_out = WRITE_EN & gear_ok & r.diff & ~r.wsc; // RL2
    next_r.dq_oe    = WRITE_EN;
    next_r.dq_out   = (gear_ok && !r.gear_a) ? WR_DATA_FALL : WR_DATA_RISE;
    next_r.cmd_out  = CMD_IN; // RL18
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      r       <= '0;
      r.wldly <= `DSC_WLDLY_RST;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs.
  // ----------------------------------------------------------------------
  assign PRDATA                    = r.prdata;
  assign PREADY                    = r.pready;
  assign PSLVERR                   = r.pslverr;
  assign CMD_OUT                   = r.cmd_out;
  assign STROBE_OUT                = r.strobe_out;
  assign STROBE_COMP_OUT           = r.strobe_comp_out;
  assign STROBE_OE                 = r.strobe_oe;
  assign DQ_OUT                    = r.dq_out;
  assign DQ_OE                     = r.dq_oe;
  assign DLL_DELAY_CODE            = r.code;
  assign DELAYED_READ_STROBE_CLOCK = r.drs;
  assign SYNC_CLOCK_POLARITY       = r.polarity;
  assign GEARBOX_TRANSFER_LATCH    = r.latch;
  assign RD_DATA_RISE              = r.rd_rise;
  assign RD_DATA_FALL              = r.rd_fall;
  assign RD_DATA_RISE_B            = r.rd_rise_b;
  assign RD_DATA_FALL_B            = r.rd_fall_b;
  assign RD_VALID                  = r.rd_valid;
  assign WRITE_GEAR_CLOCK_A        = r.gear_a;
  assign WRITE_GEAR_CLOCK_B        = r.gear_b;
  assign WRITE_STROBE_CLOCK        = r.wsc;

  // ----------------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------------
  default clocking dsc_cb @(posedge CLK);
  endclocking
  default disable iff (RESET);

  group_width_a: assert property (DQ_W == 10 || DQ_W == GROUP_DATA) // RL5
    else $error("data width does not fit the strobe group");

  code_step_a: assert property ( // RL7
    r.code == $past(r.code) || r.code == $past(r.code) + 7'h1 ||
    r.code == $past(r.code) - 7'h1)
    else $error("delay code moved by more than one step");

  pol_hold_a: assert property ( // RL21
    (r.rd_state == DSC_RD_BURST && $past(r.rd_state) == DSC_RD_BURST)
    |-> $stable(r.polarity))
    else $error("polarity changed inside a read burst");

  pol_pick_a: assert property ( // RL12
    (r.rd_state == DSC_RD_FIRST && s_rise) |=>
    (r.rd_state == DSC_RD_BURST && r.polarity == $past(r.phase)))
    else $error("polarity not taken at first strobe rise");

  bottom_idle_a: assert property ( // RL3
    (r.edge_sel == DSC_EDGE_BOTTOM && r.rd_state == DSC_RD_IDLE)
    |=> r.rd_state == DSC_RD_IDLE ##0 !r.latch)
    else $error("read started on the bottom edge");

  no_gear_a: assert property ( // RL4
    (r.edge_sel == DSC_EDGE_TOP || r.edge_sel == DSC_EDGE_BOTTOM)
    |=> (!r.gear_a && !r.gear_b && !r.strobe_oe))
    else $error("output gearing active without gearing support");

  latch_mode_a: assert property ( // RL13
    r.latch |-> ($past(r.gear2) && $past(xfer) && r.rd_valid))
    else $error("transfer latch outside double gearbox mode");

  gear_quad_a: assert property ( // RL14
    $rose(r.gear_a) |-> r.gear_b ##1 !r.gear_b)
    else $error("gearing clocks lost quadrature");

  apb_ready_a: assert property (
    (PSEL && !PENABLE) |=> r.pready ##1 !r.pready)
    else $error("bus answer not exactly one cycle after setup");

endmodule

// File: test/dsc_mem_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// Memory side of the read link: preamble, strobe and edge-aligned data.
// ----------------------------------------------------------------------
module dsc_mem_model (
  input  wire logic       go,
  input  wire logic [9:0] seed,
  output      logic       strobe,
  output      logic       strobe_n,
  output      logic [9:0] dq,
  output      logic       busy
);
  assign strobe_n = ~strobe;
  initial begin
    strobe = 1'b1;
    dq = 10'h000;
    busy = 1'b0;
  end
  // Released data lines change every half period.
  always begin
    #80;
    if (!busy) dq = ~dq;
  end
  always @(posedge go) begin
    busy = 1'b1;
    #3;
    strobe = 1'b0;
    #80;
    for (int j = 0; j < 8; j++) begin
      dq = seed + 10'(j);
      strobe = ~j[0];
      #80;
    end
    strobe = 1'b1;
    dq = ~dq;
    busy = 1'b0;
  end
endmodule

// File: test/testbench.sv
`timescale 1ns/10ps
`include "dsc_cfg.svh"
module testbench;
  import dsc_pkg::*;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  logic        CLK, RESET, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA;
  logic        STROBE_IN, STROBE_COMP_IN, READ_START, WRITE_EN, STROBE_OE;
  logic [9:0]  DQ_IN, WR_DATA_RISE, RD_DATA_RISE, RD_DATA_FALL;
  logic [9:0]  RD_DATA_RISE_B, RD_DATA_FALL_B;
  logic [7:0]  CMD_IN, CMD_OUT, wl;
  logic        RD_VALID, GEARBOX_TRANSFER_LATCH, WRITE_STROBE_CLOCK;
  logic        WRITE_GEAR_CLOCK_A, WRITE_GEAR_CLOCK_B, go, busy;
  logic        DQ_OE, STROBE_OUT;
  logic [9:0]  seed;
  logic [16:0] rng;
  logic [64:0] ae;
  logic [40:0] re;
  logic [64:0] aq [$];
  logic [40:0] rq [$];
  bit          quiet, gear2;
  int          err_count, comparisons, cyc;

  dsc_strobe_ctrl DUT (.CLK(CLK), .RESET(RESET), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .STROBE_IN(STROBE_IN), .STROBE_COMP_IN(STROBE_COMP_IN), .DQ_IN(DQ_IN),
    .READ_START(READ_START), .WRITE_EN(WRITE_EN),
    .WR_DATA_RISE(WR_DATA_RISE), .WR_DATA_FALL(~WR_DATA_RISE),
    .CMD_IN(CMD_IN), .CMD_OUT(CMD_OUT), .STROBE_OUT(STROBE_OUT),
    .STROBE_COMP_OUT(),
    .STROBE_OE(STROBE_OE), .DQ_OUT(), .DQ_OE(DQ_OE), .DLL_DELAY_CODE(),
    .DELAYED_READ_STROBE_CLOCK(), .SYNC_CLOCK_POLARITY(),
    .GEARBOX_TRANSFER_LATCH(GEARBOX_TRANSFER_LATCH),
    .RD_DATA_RISE(RD_DATA_RISE), .RD_DATA_FALL(RD_DATA_FALL),
    .RD_DATA_RISE_B(RD_DATA_RISE_B), .RD_DATA_FALL_B(RD_DATA_FALL_B),
    .RD_VALID(RD_VALID), .WRITE_GEAR_CLOCK_A(WRITE_GEAR_CLOCK_A),
    .WRITE_GEAR_CLOCK_B(WRITE_GEAR_CLOCK_B),
    .WRITE_STROBE_CLOCK(WRITE_STROBE_CLOCK));
  dsc_mem_model u_mem (.go(go), .seed(seed), .strobe(STROBE_IN),
    .strobe_n(STROBE_COMP_IN), .dq(DQ_IN), .busy(busy));

  // ----------------------------------------------------------------------
  // Helpers.
  // ----------------------------------------------------------------------
  function automatic logic [16:0] lfsr(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction
  task automatic cmp(input logic [40:0] g, input logic [40:0] e);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_reg(input logic [32:0] g, input logic [32:0] e);
    cmp(41'(g), 41'(e));
  endtask
  task automatic chk_rd(input logic [40:0] g, input logic [40:0] e);
    cmp(g, e);
  endtask
  task automatic chk_pin(input logic [7:0] g, input logic [7:0] e);
    cmp(41'(g), 41'(e));
  endtask
  task automatic note(input string s);
    $display("test %s finished", s);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Bus master and read link driver.
  // ----------------------------------------------------------------------
  task automatic apb(input bit w, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] m, input logic e);
    int n;
    @(posedge CLK);
    aq.push_back({m, e, d & m});
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 50);
    if (n >= 50) err_count++;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic burst(input bit chk, input bit g2);
    logic [9:0] b [8];
    int n;
    gear2 = g2;
    for (int k = 0; k < 8; k++) b[k] = rng[9:0] + 10'(k);
    for (int k = 0; k < 4; k++) begin
      if (chk && g2 && k[0]) rq.push_back({1'b1, b[2*k-2], b[2*k-1],
                                           b[2*k], b[2*k+1]});
      if (chk && !g2) rq.push_back({1'b0, 20'h0_0000, b[2*k], b[2*k+1]});
    end
    seed <= rng[9:0];
    rng = lfsr(rng);
    @(posedge CLK);
    READ_START <= 1'b1;
    @(posedge CLK);
    READ_START <= 1'b0;
    go <= 1'b1;
    @(posedge CLK);
    go <= 1'b0;
    n = 0;
    while (busy !== 1'b0 && n < 200) begin
      @(posedge CLK);
      n++;
    end
    if (n >= 200) err_count++;
    repeat (20) @(posedge CLK);
  endtask
  task automatic pins(input bit top, input int d, input logic inv);
    logic [63:0] ha;
    logic [63:0] hb;
    logic [7:0]  c1;
    logic [7:0]  c2;
    ha = '0;
    hb = '0;
    c1 = '0;
    c2 = '0;
    for (int i = 0; i < 48; i++) begin
      @(posedge CLK);
      ha = {ha[62:0], WRITE_GEAR_CLOCK_A};
      hb = {hb[62:0], WRITE_GEAR_CLOCK_B};
      if (i > 1) chk_pin(CMD_OUT, c2);
      if (top) chk_pin(8'(ha[0] | hb[0] | STROBE_OUT), 8'h00);
      else if (i > d) chk_pin(8'({DQ_OE, STROBE_OE, hb[1],
                                  WRITE_STROBE_CLOCK, STROBE_OUT}),
                              8'({2'b11, ha[0], ha[d] ^ inv,
                                  ha[d+1] ^ inv}));
      c2 = c1;
      c1 = rng[7:0];
      CMD_IN <= c1;
      WR_DATA_RISE <= rng[9:0];
      rng = lfsr(rng);
    end
  endtask

  // ----------------------------------------------------------------------
  // Result monitor and timeout.
  // ----------------------------------------------------------------------
  always @(posedge CLK) begin
    if (!RESET && PREADY === 1'b1) begin
      ae = aq.size() ? aq.pop_front() : {ALL, 33'hx};
      chk_reg({PSLVERR, PRDATA & ae[64:33]}, ae[32:0]);
    end
    if (!RESET && RD_VALID === 1'b1 && !quiet) begin
      re = rq.size() ? rq.pop_front() : 41'hx;
      chk_rd({GEARBOX_TRANSFER_LATCH, gear2 ? {RD_DATA_RISE_B,
              RD_DATA_FALL_B} : 20'h0_0000, RD_DATA_RISE, RD_DATA_FALL},
             re);
    end
  end
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 6000) begin
      err_count++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------------
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  initial begin
    {PSEL, PENABLE, PWRITE, READ_START, WRITE_EN, go} = '0;
    {PADDR, PWDATA, CMD_IN, WR_DATA_RISE, seed} = '0;
    RESET = 1'b1;
    rng = 17'h1_2C83;
    repeat (6) @(posedge CLK);
    RESET <= 1'b0;
    apb(0, `DSC_ADDR_CTRL, 32'h0000_0000, ALL, 0);
    apb(0, `DSC_ADDR_WLDLY, 32'h0000_0000, ALL, 0);
    apb(1, `DSC_ADDR_STAT, ALL, 32'h0000_0000, 0);
    apb(0, `DSC_ADDR_STAT, 32'h0000_0008, ALL, 0);
    apb(0, 12'h010, 32'h0000_0000, ALL, 1);
    note("registers");
    for (int b = 0; b < 8; b++) begin
      apb(1, `DSC_ADDR_CTRL, 32'(b) << 4, 32'h0000_0000, 0);
      apb(0, `DSC_ADDR_STAT, 32'(b == 0 || b > 5) << 3, ALL, 0);
    end
    apb(1, `DSC_ADDR_CTRL, 32'h0000_0000, 32'h0000_0000, 0);
    note("banks");
    quiet = 1;
    burst(0, 0);
    burst(0, 0);
    quiet = 0;
    apb(0, `DSC_ADDR_CODE, 32'h0000_0004, 32'h0000_007F, 0);
    burst(1, 0);
    apb(1, `DSC_ADDR_CTRL, 32'h0000_0004, 32'h0000_0000, 0);
    burst(1, 0);
    apb(1, `DSC_ADDR_CTRL, 32'h0000_0008, 32'h0000_0000, 0);
    burst(1, 1);
    chk_rd(41'(rq.size()), 41'h0);
    note("reads");
    quiet = 1;
    apb(1, `DSC_ADDR_CTRL, 32'(DSC_EDGE_BOTTOM), 32'h0000_0000, 0);
    burst(0, 0);
    apb(0, `DSC_ADDR_STAT, 32'h0000_0000, 32'h0000_0006, 0);
    apb(1, `DSC_ADDR_CTRL, 32'(DSC_EDGE_TOP), 32'h0000_0000, 0);
    pins(1, 0, 1'b0);
    quiet = 0;
    note("edges");
    wl = rng[7:0] & 8'h9F;
    rng = lfsr(rng);
    apb(1, `DSC_ADDR_CTRL, 32'h0000_0000, 32'h0000_0000, 0);
    apb(1, `DSC_ADDR_WLDLY, 32'(wl), 32'h0000_0000, 0);
    apb(0, `DSC_ADDR_WLDLY, 32'(wl), ALL, 0);
    WRITE_EN <= 1'b1;
    repeat (4) @(posedge CLK);
    pins(0, 6 + int'(wl[6:0]), wl[7]);
    WRITE_EN <= 1'b0;
    note("writes");
    end_of_test();
  end
endmodule
